// ===== src/scrf_pkg.sv
// Package for the receive address, length and flow filter.
// Assumes a 32-bit register port with byte addresses and one clock domain.
package scrf_pkg;
  localparam logic [11:0] SCRF_OFF_ADDR    = 12'h138;
  localparam logic [11:0] SCRF_OFF_MASK    = 12'h13c;
  localparam logic [11:0] SCRF_OFF_LEN     = 12'h140;
  localparam logic [11:0] SCRF_OFF_FLOW    = 12'h144;
  localparam logic [11:0] SCRF_OFF_STATUS  = 12'h160;
  localparam logic [31:0] SCRF_RESET_VALUE = 32'h00000000;
  localparam int          SCRF_LEN_EN_BIT  = 15;
  localparam int          SCRF_POLARITY_BIT = 25;
  localparam logic [31:0] SCRF_LEN_MASK    = 32'h000087ff;
  localparam int          SCRF_LIMIT_SHIFT = 5;
  localparam logic [1:0]  SCRF_CHAR_LEN_8  = 2'h3;
  typedef enum logic [1:0] {SCRF_IDLE, SCRF_ADDR_HI, SCRF_ADDR_LO, SCRF_BODY} scrf_state_e;
endpackage

// ===== src/scrf_filter.sv
// Receive-side filter: HDLC address match, command/response bit, length check, XON/XOFF detection.
// Assumes received bytes and characters arrive as one-cycle strobes from logic on the same clock.
`timescale 1ns/1ns
// Overview of operation
// - Report C/R bit per polarity setting.
// - 16-bit mode compares address 1 low byte.
// - 8-bit mode: address 1 low means command.
// - 8-bit mode: address 2 low means response.
// - Mask bit one forces that bit match.
// - Mask register holds four byte masks.
// - Length check off when enable bit clear.
// - Count every frame byte against limit.
// - Overlong frame is handled as abort.
// - Overlong frame also raises too-long event.
// - Status byte counts toward length.
// - Limit is (field plus one) times 32.
// - Only char-length low bits are compared.
// - Only clean, correctly framed characters qualify.
// - XON recognised on unmasked bit equality.
// - XON stored, event raised, transmitter resumed unless XOFF also matches.
// - XOFF stored, event raised, transmitter paused.
// - Flow mask bit one forces a match.
module scrf_filter
  import scrf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [31:0] reg_rdata,
  input  wire logic        hdlc_mode,
  input  wire logic        addr_two_byte,
  input  wire logic        rx_frame_start,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_line_abort,
  input  wire logic        async_mode,
  input  wire logic [1:0]  char_length_field,
  input  wire logic        rx_char_valid,
  input  wire logic [7:0]  rx_char,
  input  wire logic        rx_char_framing_ok,
  input  wire logic        parity_check_enable,
  input  wire logic        rx_char_parity_ok,
  input  wire logic        inband_flow_enable,
  input  wire logic        resume_irq_enable,
  input  wire logic        pause_irq_enable,
  input  wire logic        too_long_irq_enable,
  output logic             frame_accept,
  output logic             frame_reject,
  output logic             rx_cmd_resp_bit,
  output logic             rx_abort_event,
  output logic             frame_too_long_event,
  output logic             resume_event,
  output logic             pause_event,
  output logic             tx_paused,
  output logic             rx_fifo_write,
  output logic      [7:0]  rx_fifo_data
);
  import scrf_pkg::*;

  // Software-visible registers.
  logic [31:0] addr_r, mask_r, len_r, flow_r;
  scrf_state_e state_r;
  logic [15:0] count_r;
  logic        cmd_r, hit1_r, hit2_r, dropped_r;

  // Masked byte compare: a one in the mask always matches.
  function automatic logic byte_hit(input logic [7:0] rx, input logic [7:0] ref_b, input logic [7:0] msk);
    byte_hit = &(~(rx ^ ref_b) | msk);
  endfunction

  // Significant bits for the configured character length.
  function automatic logic [7:0] len_mask(input logic [1:0] char_len);
    len_mask = 8'hff >> (SCRF_CHAR_LEN_8 - char_len);
  endfunction

  // Register fields.
  wire logic [7:0] a1_hi = addr_r[31:24];
  wire logic [7:0] a1_lo = addr_r[23:16];
  wire logic [7:0] a2_hi = addr_r[15:8];
  wire logic [7:0] a2_lo = addr_r[7:0];
  wire logic [7:0] m2_hi = mask_r[31:24];
  wire logic [7:0] m2_lo = mask_r[23:16];
  wire logic [7:0] m1_hi = mask_r[15:8];
  wire logic [7:0] m1_lo = mask_r[7:0];
  wire logic       cmd_resp_polarity = addr_r[SCRF_POLARITY_BIT];
  wire logic       len_en = len_r[SCRF_LEN_EN_BIT];
  wire logic [15:0] limit = 16'((len_r[10:0] + 16'h1) << SCRF_LIMIT_SHIFT);

  // Address decode and write strobes.
  wire logic wr_addr = reg_write && reg_addr == SCRF_OFF_ADDR;
  wire logic wr_mask = reg_write && reg_addr == SCRF_OFF_MASK;
  wire logic wr_len  = reg_write && reg_addr == SCRF_OFF_LEN;
  wire logic wr_flow = reg_write && reg_addr == SCRF_OFF_FLOW;
  wire logic [31:0] status_word = {28'h0, tx_paused, dropped_r, hit2_r, hit1_r};
  wire logic [31:0] rd_nxt = (reg_addr == SCRF_OFF_ADDR)   ? addr_r :
                             (reg_addr == SCRF_OFF_MASK)   ? mask_r :
                             (reg_addr == SCRF_OFF_LEN)    ? len_r  :
                             (reg_addr == SCRF_OFF_FLOW)   ? flow_r :
                             (reg_addr == SCRF_OFF_STATUS) ? status_word : SCRF_RESET_VALUE;

  // Address byte comparisons. In 1-byte mode the high byte of address 1 is unused apart from bit 1, the C/R polarity bit.
  wire logic in_hi    = state_r == SCRF_ADDR_HI;
  wire logic in_lo    = state_r == SCRF_ADDR_LO;
  wire logic hi1_hit  = byte_hit({rx_byte[7:2], 1'b0, rx_byte[0]}, {a1_hi[7:2], 1'b0, a1_hi[0]}, m1_hi);
  wire logic hi2_hit  = byte_hit(rx_byte, a2_hi, m2_hi);
  wire logic lo1_hit  = byte_hit(rx_byte, a1_lo, m1_lo);
  wire logic lo2_hit  = byte_hit(rx_byte, a2_lo, m2_lo);
  wire logic addr_done = rx_byte_valid && in_lo;
  wire logic final1   = addr_two_byte ? hit1_r && lo1_hit : lo1_hit;
  wire logic final2   = addr_two_byte ? hit2_r && lo2_hit : lo2_hit;
  wire logic accept_now = addr_done && (final1 || final2);
  // C/R bit: with polarity one, command reads 0; polarity zero inverts.
  wire logic cr_raw   = addr_two_byte ? cmd_r : !lo1_hit;
  wire logic cr_nxt   = cmd_resp_polarity ? cr_raw : !cr_raw;

  // Length check counts each byte into the FIFO plus the status byte at frame end.
  wire logic in_frame = state_r != SCRF_IDLE && !dropped_r;
  wire logic counted  = in_frame && (rx_byte_valid || rx_frame_end);
  wire logic [15:0] count_nxt = count_r + 16'h1;
  wire logic overflow = hdlc_mode && len_en && counted && count_nxt > limit;

  // Character qualification and flow detection.
  wire logic [7:0] sig = len_mask(char_length_field);
  wire logic char_ok = async_mode && rx_char_valid && rx_char_framing_ok &&
                       (!parity_check_enable || rx_char_parity_ok);
  wire logic xon_hit  = char_ok && byte_hit(rx_char & sig, flow_r[31:24] & sig, flow_r[15:8] | ~sig);
  wire logic xoff_hit = char_ok && byte_hit(rx_char & sig, flow_r[23:16] & sig, flow_r[7:0] | ~sig);

  // Frame sequencer.
  wire logic byte_in = rx_byte_valid && hdlc_mode;
  scrf_state_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SCRF_IDLE:    if (rx_frame_start && hdlc_mode) state_nxt = addr_two_byte ? SCRF_ADDR_HI : SCRF_ADDR_LO;
      SCRF_ADDR_HI: if (byte_in) state_nxt = SCRF_ADDR_LO;
      SCRF_ADDR_LO: if (byte_in) state_nxt = SCRF_BODY;
      SCRF_BODY:    state_nxt = SCRF_BODY;
    endcase
    if (rx_frame_end || rx_line_abort) state_nxt = SCRF_IDLE;
  end

  // Register writes.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      addr_r <= SCRF_RESET_VALUE;
      mask_r <= SCRF_RESET_VALUE;
      len_r  <= SCRF_RESET_VALUE;
      flow_r <= SCRF_RESET_VALUE;
      reg_rdata <= SCRF_RESET_VALUE;
    end else begin
      if (wr_addr) addr_r <= reg_wdata;
      if (wr_mask) mask_r <= reg_wdata;
      if (wr_len)  len_r  <= reg_wdata & SCRF_LEN_MASK;
      if (wr_flow) flow_r <= reg_wdata;
      reg_rdata <= reg_read ? rd_nxt : SCRF_RESET_VALUE;
    end
  end

  // Frame state, address results and length counter.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_r <= SCRF_IDLE;
      count_r <= 16'h0;
      hit1_r <= 1'b0;
      hit2_r <= 1'b0;
      cmd_r <= 1'b0;
      dropped_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (rx_frame_start) begin
        count_r <= 16'h0;
        dropped_r <= 1'b0;
        hit1_r <= 1'b0;
        hit2_r <= 1'b0;
      end else if (counted) count_r <= count_nxt;
      if (overflow) dropped_r <= 1'b1;
      if (byte_in && in_hi) begin
        hit1_r <= hi1_hit;
        hit2_r <= hi2_hit;
        cmd_r <= rx_byte[1];
      end
      if (addr_done) begin
        hit1_r <= final1;
        hit2_r <= final2;
      end
    end
  end

  // Event pulses and frame results.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_accept <= 1'b0;
      frame_reject <= 1'b0;
      rx_cmd_resp_bit <= 1'b0;
      rx_abort_event <= 1'b0;
      frame_too_long_event <= 1'b0;
    end else begin
      frame_accept <= accept_now;
      frame_reject <= addr_done && !(final1 || final2);
      if (addr_done) rx_cmd_resp_bit <= cr_nxt;
      rx_abort_event <= overflow || (rx_line_abort && state_r != SCRF_IDLE && !dropped_r);
      frame_too_long_event <= overflow && too_long_irq_enable;
    end
  end

  // Character pass-through and flow state; recognised characters still go to the FIFO.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rx_fifo_write <= 1'b0;
      rx_fifo_data <= 8'h0;
      resume_event <= 1'b0;
      pause_event <= 1'b0;
      tx_paused <= 1'b0;
    end else begin
      rx_fifo_write <= (async_mode && rx_char_valid) || (in_frame && byte_in && !overflow);
      rx_fifo_data <= async_mode ? (rx_char & sig) : rx_byte;
      resume_event <= xon_hit && resume_irq_enable;
      pause_event <= xoff_hit && pause_irq_enable;
      if (!inband_flow_enable) tx_paused <= 1'b0;
      else if (xoff_hit) tx_paused <= 1'b1;
      else if (xon_hit) tx_paused <= 1'b0;
    end
  end

  // Checks on the filter behaviour.
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  xoff_pause_a: assert property (xoff_hit && inband_flow_enable |=> tx_paused) else $error("XOFF did not pause.");
  xon_resume_a: assert property (xon_hit && !xoff_hit && inband_flow_enable |=> !tx_paused) else $error("XON did not resume.");
  xon_event_a: assert property (xon_hit && resume_irq_enable |=> resume_event) else $error("XON event missing.");
  bad_char_a: assert property (rx_char_valid && !rx_char_framing_ok |=> !resume_event && !pause_event) else $error("Bad char matched.");
  flow_store_a: assert property (char_ok |=> rx_fifo_write) else $error("Flow char not stored.");
  len_off_a: assert property (!len_en |=> !frame_too_long_event) else $error("Length check while off.");
  over_abort_a: assert property (overflow |=> rx_abort_event) else $error("Overflow not aborted.");
  over_frame_too_long_event_a: assert property (overflow && too_long_irq_enable |=> frame_too_long_event) else $error("Too-long missing.");
  count_lim_a: assert property (hdlc_mode && len_en && in_frame |-> count_r <= limit) else $error("Count over limit.");
  accept_a: assert property (addr_done && final1 |=> frame_accept) else $error("Address 1 not accepted.");
  both_a: assert property (!(frame_accept && frame_reject)) else $error("Accept and reject together.");
  accept_c: cover property (frame_accept);
  reject_c: cover property (frame_reject);
  too_long_c: cover property (frame_too_long_event);
  pause_c: cover property (pause_event ##[1:20] resume_event);
  drop_c: cover property (rx_abort_event && frame_too_long_event);

  // Further checks, grouped by interface.
  // The register port answers only in the slot after a read strobe.
  // The address checks compare against the rules, not against cr_nxt.
  // The length checks watch overflow, dropped frames, the abort and too-long events, and the count and state at frame start and end.
  // The character checks watch events and the flow state.

  // Read data are zero outside the slot after a read.
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == SCRF_RESET_VALUE)
    else $error("Read data outside read slot.");

  // Unused length bits always read as zero.
  len_read_a: assert property (reg_read && reg_addr == SCRF_OFF_LEN |=> (reg_rdata & ~SCRF_LEN_MASK) == 32'h0)
    else $error("Length reserved bits set.");

  // A mask write lands whole.
  mask_write_a: assert property (wr_mask |=> mask_r == $past(reg_wdata))
    else $error("Mask write lost.");

  // An address write lands whole.
  addr_write_a: assert property (wr_addr |=> addr_r == $past(reg_wdata))
    else $error("Address write lost.");

  // A length write keeps only the enable and limit fields.
  len_write_a: assert property (wr_len |=> len_r == ($past(reg_wdata) & SCRF_LEN_MASK))
    else $error("Length write wrong.");

  // The status word shows the flow state of the read cycle.
  status_read_a: assert property (reg_read && reg_addr == SCRF_OFF_STATUS |=> reg_rdata[3] == $past(tx_paused))
    else $error("Status flow bit wrong.");

  // A match on address 2 accepts the frame.
  accept2_a: assert property (addr_done && final2 |=> frame_accept)
    else $error("Address 2 not accepted.");

  // No match on either address rejects the frame.
  reject_a: assert property (addr_done && !final1 && !final2 |=> frame_reject)
    else $error("Frame not rejected.");

  // Results appear only after the last address byte.
  no_result_a: assert property (!addr_done |=> !frame_accept && !frame_reject)
    else $error("Stray address result.");

  // The C/R report holds between address results.
  cr_hold_a: assert property (!addr_done |=> $stable(rx_cmd_resp_bit))
    else $error("C/R report moved.");

  // One-byte command address reports the inverse of the polarity bit.
  cmd_bit_a: assert property (addr_done && !addr_two_byte && lo1_hit |=> rx_cmd_resp_bit == !$past(cmd_resp_polarity))
    else $error("Command report wrong.");

  // One-byte response address reports the polarity bit itself.
  resp_bit_a: assert property (addr_done && !addr_two_byte && !lo1_hit && lo2_hit |=> rx_cmd_resp_bit == $past(cmd_resp_polarity))
    else $error("Response report wrong.");

  // No length overflow outside HDLC mode.
  no_len_ovf_a: assert property (!hdlc_mode |-> !overflow)
    else $error("Overflow outside HDLC.");

  // A dropped frame writes no more bytes.
  drop_quiet_a: assert property (dropped_r && !async_mode |=> !rx_fifo_write)
    else $error("Dropped frame still written.");

  // The too-long event stays off while not enabled.
  frame_too_long_event_off_a: assert property (overflow && !too_long_irq_enable |=> !frame_too_long_event)
    else $error("Too-long event while disabled.");

  // The too-long event needs an overflow.
  frame_too_long_event_quiet_a: assert property (!overflow |=> !frame_too_long_event)
    else $error("Too-long event without overflow.");

  // A line abort inside a kept frame is reported.
  abort_line_a: assert property (rx_line_abort && state_r != SCRF_IDLE && !dropped_r |=> rx_abort_event)
    else $error("Line abort lost.");

  // No abort event without a cause.
  abort_quiet_a: assert property (!rx_line_abort && !overflow |=> !rx_abort_event)
    else $error("Stray abort event.");

  // A new frame starts its count from zero.
  count_reset_a: assert property (rx_frame_start |=> count_r == 16'h0)
    else $error("Count not cleared.");

  // The status byte slot closes the frame.
  frame_close_a: assert property (rx_frame_end |=> state_r == SCRF_IDLE)
    else $error("Frame not closed.");

  // XOFF raises its event when enabled.
  xoff_event_a: assert property (xoff_hit && pause_irq_enable |=> pause_event)
    else $error("XOFF event missing.");

  // Unqualified characters raise no flow event.
  no_event_a: assert property (!char_ok |=> !resume_event && !pause_event)
    else $error("Event from bad char.");

  // Bad parity blocks recognition when checking is on.
  parity_a: assert property (rx_char_valid && parity_check_enable && !rx_char_parity_ok |=> !resume_event && !pause_event)
    else $error("Bad parity matched.");

  // Flow control off keeps the transmitter running.
  flow_off_a: assert property (!inband_flow_enable |=> !tx_paused)
    else $error("Paused with flow off.");

  // Without a flow character the flow state holds.
  pause_hold_a: assert property (!xon_hit && !xoff_hit && inband_flow_enable |=> $stable(tx_paused))
    else $error("Flow state moved.");

  // Stored characters keep only their significant bits.
  fifo_data_a: assert property (async_mode && rx_char_valid |=> rx_fifo_data == ($past(rx_char) & $past(sig)))
    else $error("Stored char wrong.");

  // Nothing is written while neither mode is on.
  no_mode_a: assert property (!async_mode && !hdlc_mode |=> !rx_fifo_write)
    else $error("Write with no mode.");
endmodule

// ===== test/scrf_line_model.sv
// Remote station model: sends HDLC frames, line aborts and async characters.
// Assumes the filter samples every strobe on the rising edge of clock.
`timescale 1ns/1ns
module scrf_line_model (
  input  wire logic       clock,
  output logic            rx_frame_start = 1'b0,
  output logic            rx_byte_valid = 1'b0,
  output logic      [7:0] rx_byte = 8'h00,
  output logic            rx_frame_end = 1'b0,
  output logic            rx_line_abort = 1'b0,
  output logic            rx_char_valid = 1'b0,
  output logic      [7:0] rx_char = 8'h00,
  output logic            rx_char_framing_ok = 1'b0,
  output logic            rx_char_parity_ok = 1'b0
);
  // Start, address byte or bytes, n filler bytes, then the status byte slot.
  task automatic frame(input logic two, input logic [7:0] hi, input logic [7:0] lo, input int n);
    rx_frame_start <= 1'b1;
    @(posedge clock);
    rx_frame_start <= 1'b0;
    for (int i = 0; i < n + 1 + int'(two); i++) begin
      rx_byte_valid <= 1'b1;
      rx_byte <= (two && i == 0) ? hi : (i == int'(two)) ? lo : 8'(i);
      @(posedge clock);
    end
    rx_byte_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    rx_frame_end <= 1'b1;
    @(posedge clock);
    rx_frame_end <= 1'b0;
  endtask
  // A frame opening, then an abort sequence seen on the line.
  task automatic line_abort();
    rx_frame_start <= 1'b1;
    @(posedge clock);
    rx_frame_start <= 1'b0;
    rx_line_abort <= 1'b1;
    @(posedge clock);
    rx_line_abort <= 1'b0;
  endtask
  // One character with its framing and parity flags; idle data is inverted.
  task automatic chr(input logic [7:0] c, input logic fok, input logic pok);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    rx_char_framing_ok <= fok;
    rx_char_parity_ok <= pok;
    @(posedge clock);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask
endmodule

// ===== test/scrf_filter_tb.sv
// Bench for the receive filter: registers, address rows, character rows, length cases.
// Assumes the line model drives the receive strobes and the bench drives registers and config.
`timescale 1ns/1ns
module scrf_filter_tb;
  import scrf_pkg::*;
  typedef struct packed {logic two; logic [31:0] addr; logic [7:0] hi; logic [7:0] lo; logic [2:0] e;} scrf_frow_s;
  typedef struct packed {logic [1:0] clen; logic [3:0] f; logic [7:0] c; logic [3:0] e;} scrf_crow_s;
  logic        clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, clr = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic        hdlc_mode = 1'b1, addr_two_byte = 1'b1, async_mode = 1'b0, parity_check_enable = 1'b0;
  logic [1:0]  char_length_field = 2'h3;
  logic        inband_flow_enable = 1'b1, resume_irq_enable = 1'b1, pause_irq_enable = 1'b1;
  logic        too_long_irq_enable = 1'b1, rx_frame_start, rx_byte_valid, rx_frame_end, rx_line_abort;
  logic        rx_char_valid, rx_char_framing_ok, rx_char_parity_ok, frame_accept, frame_reject;
  logic        rx_cmd_resp_bit, rx_abort_event, frame_too_long_event, resume_event, pause_event;
  logic        tx_paused, rx_fifo_write;
  logic [7:0]  rx_byte, rx_char, rx_fifo_data, got_fd;
  logic [6:0]  got = 7'h0;
  int          fails = 0, samples_checked = 0;
  scrf_frow_s  fr [10];
  scrf_crow_s  cr [8];
  scrf_filter scrf_filter_i (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .hdlc_mode, .addr_two_byte, .rx_frame_start, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_line_abort,
    .async_mode, .char_length_field, .rx_char_valid, .rx_char, .rx_char_framing_ok, .parity_check_enable,
    .rx_char_parity_ok, .inband_flow_enable, .resume_irq_enable, .pause_irq_enable, .too_long_irq_enable,
    .frame_accept, .frame_reject, .rx_cmd_resp_bit, .rx_abort_event, .frame_too_long_event, .resume_event,
    .pause_event, .tx_paused, .rx_fifo_write, .rx_fifo_data);
  scrf_line_model scrf_line_model_i (.clock, .rx_frame_start, .rx_byte_valid, .rx_byte, .rx_frame_end,
    .rx_line_abort, .rx_char_valid, .rx_char, .rx_char_framing_ok, .rx_char_parity_ok);
  // Free-running 50 MHz clock.
  always #10 clock = ~clock;
  // Sticky capture of event pulses so each test looks at a whole window.
  always @(posedge clock) begin
    got <= clr ? 7'h0 : got | {frame_accept, frame_reject, rx_abort_event, frame_too_long_event,
      resume_event, pause_event, rx_fifo_write};
    if (rx_fifo_write) begin
      got_fd <= rx_fifo_data;
    end
  end
  task automatic clear();
    clr <= 1'b1;
    @(posedge clock);
    clr <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  // Read strobe for one cycle; the data are taken in the cycle after it.
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string n);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    chk(n, e, reg_rdata);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence: reset, registers, rows, then the hand-written length cases.
  initial begin
    fr = '{'{1,32'h40218055,8'h40,8'h21,3'h4}, '{1,32'h40218055,8'h40,8'h22,3'h0},
      '{1,32'h40218055,8'h80,8'h5a,3'h4}, '{1,32'h40218055,8'h80,8'h65,3'h0},
      '{1,32'h40218055,8'h42,8'h21,3'h6}, '{0,32'h02210055,8'h00,8'h21,3'h6},
      '{0,32'h02210055,8'h00,8'h55,3'h7}, '{0,32'h02210055,8'h00,8'h33,3'h0},
      '{0,32'h00210055,8'h00,8'h21,3'h7}, '{0,32'h00210055,8'h00,8'h55,3'h6}};
    cr = '{'{2'h3,4'h9,8'h11,4'hc}, '{2'h3,4'h9,8'h12,4'hb}, '{2'h3,4'h3,8'h11,4'h1},
      '{2'h3,4'hd,8'h13,4'h1}, '{2'h0,4'h9,8'hf1,4'hc}, '{2'h3,4'hf,8'h13,4'hb},
      '{2'h3,4'h9,8'h51,4'h1}, '{2'h3,4'h8,8'h11,4'h8}};
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk("idle outputs", 0, {got, tx_paused, rx_cmd_resp_bit});
    rdc(SCRF_OFF_MASK, SCRF_RESET_VALUE, "mask reset");
    rdc(SCRF_OFF_LEN, SCRF_RESET_VALUE, "length reset");
    rdc(SCRF_OFF_FLOW, SCRF_RESET_VALUE, "flow reset");
    wr(SCRF_OFF_LEN, 32'hffffffff);
    rdc(SCRF_OFF_LEN, SCRF_LEN_MASK, "length fields");
    wr(12'h100, 32'hffffffff);
    rdc(12'h100, 32'h0, "unmapped");
    wr(SCRF_OFF_MASK, 32'h000f0000);
    rdc(SCRF_OFF_MASK, 32'h000f0000, "mask fields");
    $display("register test done");
    foreach (fr[i]) begin
      wr(SCRF_OFF_ADDR, fr[i].addr);
      addr_two_byte <= fr[i].two;
      clear();
      scrf_line_model_i.frame(fr[i].two, fr[i].hi, fr[i].lo, 2);
      repeat (3) @(posedge clock);
      chk("accept", fr[i].e[2], got[6]);
      chk("reject", !fr[i].e[2], got[5]);
      if (fr[i].e[1]) chk("cmd resp", fr[i].e[0], rx_cmd_resp_bit);
      $display("frame row %0d done", i);
    end
    hdlc_mode <= 1'b0;
    async_mode <= 1'b1;
    wr(SCRF_OFF_FLOW, 32'h11130001);
    foreach (cr[i]) begin
      char_length_field <= cr[i].clen;
      {parity_check_enable, resume_irq_enable, pause_irq_enable} <= {cr[i].f[2], cr[i].f[0], cr[i].f[0]};
      clear();
      scrf_line_model_i.chr(cr[i].c, cr[i].f[3], cr[i].f[1]);
      repeat (3) @(posedge clock);
      chk("resume", cr[i].e[2], got[2]);
      chk("pause", cr[i].e[1], got[1]);
      chk("paused", cr[i].e[0], tx_paused);
      if (cr[i].e[3]) chk("fifo data", cr[i].c & (8'hff >> (2'h3 - cr[i].clen)), got_fd);
      $display("char row %0d done", i);
    end
    hdlc_mode <= 1'b1;
    async_mode <= 1'b0;
    wr(SCRF_OFF_LEN, 32'h00008000);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) wr(SCRF_OFF_LEN, 32'h0);
      clear();
      scrf_line_model_i.frame(1'b0, 8'h00, 8'h21, 30 + k);
      repeat (3) @(posedge clock);
      chk("length abort", k == 1, got[4]);
      chk("too long", k == 1, got[3]);
      $display("length case %0d done", k);
    end
    clear();
    scrf_line_model_i.line_abort();
    repeat (3) @(posedge clock);
    chk("line abort", 2'h2, got[4:3]);
    give_verdict();
  end
endmodule
